// file: inc/piw_pkg.sv
// Package with constants and types of the interrupt and wake unit
package piw_pkg;
   localparam int          NUM_SRC      = 12;
   localparam int          ID_W         = 4;
   localparam int          LVL_W        = 2;
   localparam int          NUM_LVL      = 4;
   localparam int          SYNC_STAGES  = 2;
   // Source numbers, lower number wins among equal levels
   localparam int          SRC_EXT0     = 0;
   localparam int          SRC_TMR0     = 1;
   localparam int          SRC_EXT1     = 2;
   localparam int          SRC_TMR1     = 3;
   localparam int          SRC_SER      = 4;
   localparam int          SRC_BO       = 5;
   localparam int          SRC_WDT      = 6;
   localparam int          SRC_I2C      = 7;
   localparam int          SRC_KBD      = 8;
   localparam int          SRC_CMP      = 9;
   localparam int          SRC_STX      = 10;
   localparam int          SRC_ADC      = 11;
   // Enable and priority bit positions
   localparam int          GATE_BIT     = 7;
   localparam int          REG_A_SRCS   = 7;
   localparam int          REG_B_LO_N   = 3;
   localparam int          REG_B_STX    = 6;
   localparam int          REG_B_ADC    = 7;
   // Timer control register low nibble
   localparam logic [7:0]  TCTRL_ADDR   = 8'h88;
   localparam int          TC_FLAG1     = 3;
   localparam int          TC_TYPE1     = 2;
   localparam int          TC_FLAG0     = 1;
   localparam int          TC_TYPE0     = 0;
   // Reset values
   localparam logic [3:0]  ACTIVE_RST   = 4'h0;
   localparam logic [1:0]  TRIP_RST     = 2'h0;
   localparam logic [3:0]  TCTRL_RST    = 4'h0;
   // Sources able to end power-down
   localparam logic [11:0] PD_WAKE_MASK = 12'h365;

   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_IDLE,
      PWR_PDOWN
   } piw_pwr_t;
endpackage

// file: inc/piw_arb_if.sv
// Interface between the request collector and the level arbiter
`timescale 1ns/100ps
interface piw_arb_if;
   logic [piw_pkg::NUM_SRC-1:0]                     req;
   logic [piw_pkg::NUM_SRC-1:0][piw_pkg::LVL_W-1:0] lvl;
   logic                                            win_valid;
   logic [piw_pkg::ID_W-1:0]                        win_id;
   logic [piw_pkg::LVL_W-1:0]                       win_lvl;

   modport arb (input req, input lvl, output win_valid, output win_id, output win_lvl);
   modport ctl (output req, output lvl, input win_valid, input win_id, input win_lvl);
endinterface

// file: hdl/piw_ext_pin.sv
// External request pin sampler with level and falling edge detection
`timescale 1ns/100ps
module piw_ext_pin (
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   input  wire logic i_pin,
   input  wire logic i_edge_type,
   input  wire logic i_clr,
   output logic      o_flag,
   output logic      o_req
);
   logic sync1_ff;
   logic samp_ff;
   logic prev_ff;
   logic flag_ff;
   logic fall;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sync1_ff <= 1'b1;
         samp_ff  <= 1'b1;
         prev_ff  <= 1'b1;
      end else begin
         sync1_ff <= i_pin;
         samp_ff  <= sync1_ff;
         prev_ff  <= samp_ff;
      end
   end

   assign fall = prev_ff & ~samp_ff;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         flag_ff <= 1'b0;
      end else if (i_edge_type && fall) begin
         flag_ff <= 1'b1;
      end else if (i_clr || !i_edge_type) begin
         flag_ff <= 1'b0;
      end
   end

   assign o_flag = i_edge_type ? flag_ff : ~samp_ff;
   assign o_req  = o_flag;

   a_edge_sets_flag : assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_edge_type && fall |=> flag_ff || !i_edge_type)
      else $error("Falling edge did not set the pin flag");
   a_level_follows : assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !i_edge_type |-> o_req == !samp_ff)
      else $error("Level request does not follow the pin");
   a_ack_clears_flag : assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_clr && !fall |=> !flag_ff)
      else $error("Vectoring did not clear the edge flag");
endmodule

// file: hdl/piw_arbiter.sv
// Highest level wins, fixed polling order among equal levels
`timescale 1ns/100ps
module piw_arbiter (
   piw_arb_if.arb bus
);
   always_comb begin
      bus.win_valid = 1'b0;
      bus.win_id    = '0;
      bus.win_lvl   = '0;
      for (int i = piw_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (bus.req[i] && (!bus.win_valid || bus.lvl[i] >= bus.win_lvl)) begin
            bus.win_valid = 1'b1;
            bus.win_id    = piw_pkg::ID_W'(i);
            bus.win_lvl   = bus.lvl[i];
         end
      end
   end
endmodule

// file: hdl/piw_top.sv
// Prioritized interrupt and wake unit top level
// Functional notes
// - Eleven or twelve sources, four priority levels each
// - Per-source enable bit blocks its request
// - Cleared global gate blocks every source
// - Level from low and high priority bit pair
// - Preempt active routine only for strictly higher
// - Highest level routine is never preempted
// - Higher level pending request is chosen first
// - Fixed polling order breaks equal level ties
// - Polling order never overrides level difference
// - Two pins, each with level/edge type bit
// - High then low sample sets edge flag
// - Enabled pin request wakes from idle, power-down
// - Idle keeps peripherals; enabled source ends it
// - Power-down stops oscillator; subset of sources wake
// - Brownout source enableable; two bits choose trip
// - Pin flags and types in timer control nibble
`timescale 1ns/100ps
module piw_top #(
   parameter bit HAS_ADC = 1'b1
) (
   input  wire logic                              i_clk_sys,
   input  wire logic                              i_rst,
   input  wire logic [1:0]                        i_ext_pin,
   input  wire logic [piw_pkg::NUM_SRC-1:0]       i_periph_req,
   input  wire logic                              i_brownout_det,
   input  wire logic [7:0]                        i_irq_enable_reg_a,
   input  wire logic [7:0]                        i_irq_enable_reg_b,
   input  wire logic [7:0]                        i_priority_low_reg_a,
   input  wire logic [7:0]                        i_priority_high_reg_a,
   input  wire logic [7:0]                        i_priority_low_reg_b,
   input  wire logic [7:0]                        i_priority_high_reg_b,
   input  wire logic                              i_pin0_trigger_type,
   input  wire logic                              i_pin1_trigger_type,
   input  wire logic [1:0]                        i_pin_flag_clr,
   input  wire logic                              i_brownout_irq_trip_hi,
   input  wire logic                              i_brownout_irq_trip_lo,
   input  wire logic                              i_instr_start,
   input  wire logic                              i_vector_ack,
   input  wire logic                              i_reti,
   input  wire logic                              i_idle_enter,
   input  wire logic                              i_pdown_enter,
   output logic                                   o_irq_req,
   output logic [piw_pkg::ID_W-1:0]               o_irq_id,
   output logic [piw_pkg::LVL_W-1:0]              o_irq_level,
   output logic [piw_pkg::NUM_LVL-1:0]            o_active_levels,
   output logic [3:0]                             o_timer_control_lo,
   output logic [1:0]                             o_brownout_trip_sel,
   output logic                                   o_core_run,
   output logic                                   o_periph_run,
   output logic                                   o_osc_run,
   output logic                                   o_wake
);
   piw_arb_if arb_bus ();

   logic [1:0]                                    bo_sync_ff;
   logic [1:0]                                    pin_flag;
   logic [1:0]                                    pin_req;
   logic [1:0]                                    pin_clr;
   logic [piw_pkg::NUM_SRC-1:0]                   src_raw;
   logic [piw_pkg::NUM_SRC-1:0]                   src_en;
   logic [piw_pkg::NUM_SRC-1:0]                   src_gated;
   logic [piw_pkg::NUM_SRC-1:0]                   src_hi;
   logic [piw_pkg::NUM_SRC-1:0]                   src_lo;
   logic                                          global_irq_gate;
   logic                                          irq_req_ff;
   logic [piw_pkg::ID_W-1:0]                      irq_id_ff;
   logic [piw_pkg::LVL_W-1:0]                     irq_level_ff;
   logic [piw_pkg::NUM_LVL-1:0]                   active_ff;
   logic [piw_pkg::NUM_LVL-1:0]                   nxt_active;
   logic [piw_pkg::NUM_LVL-1:0]                   reti_mask;
   logic [piw_pkg::LVL_W-1:0]                     cur_lvl;
   logic                                          any_active;
   logic                                          take;
   logic [3:0]                                    tctrl_ff;
   logic [1:0]                                    trip_ff;
   piw_pkg::piw_pwr_t                             mode_ff;
   piw_pkg::piw_pwr_t                             nxt_mode;
   logic                                          core_run_ff;
   logic                                          periph_run_ff;
   logic                                          osc_run_ff;
   logic                                          wake_ff;
   logic                                          wake_idle;
   logic                                          wake_pd;
   logic [piw_pkg::LVL_W-1:0]                     max_lvl;
   logic                                          lower_tie;

   // Brownout detector comes from the analog domain
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         bo_sync_ff <= 2'h0;
      end else begin
         bo_sync_ff <= {bo_sync_ff[0], i_brownout_det};
      end
   end

   assign pin_clr[0] = i_pin_flag_clr[0] || (i_vector_ack && irq_id_ff == piw_pkg::ID_W'(piw_pkg::SRC_EXT0));
   assign pin_clr[1] = i_pin_flag_clr[1] || (i_vector_ack && irq_id_ff == piw_pkg::ID_W'(piw_pkg::SRC_EXT1));

   piw_ext_pin u_pin0 (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_pin       (i_ext_pin[0]),
      .i_edge_type (i_pin0_trigger_type),
      .i_clr       (pin_clr[0]),
      .o_flag      (pin_flag[0]),
      .o_req       (pin_req[0])
   );

   piw_ext_pin u_pin1 (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_pin       (i_ext_pin[1]),
      .i_edge_type (i_pin1_trigger_type),
      .i_clr       (pin_clr[1]),
      .o_flag      (pin_flag[1]),
      .o_req       (pin_req[1])
   );

   // Source collection, enables, gate and levels
   always_comb begin
      src_raw                   = i_periph_req;
      src_raw[piw_pkg::SRC_EXT0] = pin_req[0];
      src_raw[piw_pkg::SRC_EXT1] = pin_req[1];
      src_raw[piw_pkg::SRC_BO]   = bo_sync_ff[1];
      src_raw[piw_pkg::SRC_ADC]  = i_periph_req[piw_pkg::SRC_ADC] & HAS_ADC;
      src_en                    = '0;
      src_hi                    = '0;
      src_lo                    = '0;
      src_en[piw_pkg::REG_A_SRCS-1:0] = i_irq_enable_reg_a[piw_pkg::REG_A_SRCS-1:0];
      src_hi[piw_pkg::REG_A_SRCS-1:0] = i_priority_high_reg_a[piw_pkg::REG_A_SRCS-1:0];
      src_lo[piw_pkg::REG_A_SRCS-1:0] = i_priority_low_reg_a[piw_pkg::REG_A_SRCS-1:0];
      for (int i = 0; i < piw_pkg::REG_B_LO_N; i++) begin
         src_en[piw_pkg::SRC_I2C + i] = i_irq_enable_reg_b[i];
         src_hi[piw_pkg::SRC_I2C + i] = i_priority_high_reg_b[i];
         src_lo[piw_pkg::SRC_I2C + i] = i_priority_low_reg_b[i];
      end
      src_en[piw_pkg::SRC_STX] = i_irq_enable_reg_b[piw_pkg::REG_B_STX];
      src_hi[piw_pkg::SRC_STX] = i_priority_high_reg_b[piw_pkg::REG_B_STX];
      src_lo[piw_pkg::SRC_STX] = i_priority_low_reg_b[piw_pkg::REG_B_STX];
      src_en[piw_pkg::SRC_ADC] = i_irq_enable_reg_b[piw_pkg::REG_B_ADC];
      src_hi[piw_pkg::SRC_ADC] = i_priority_high_reg_b[piw_pkg::REG_B_ADC];
      src_lo[piw_pkg::SRC_ADC] = i_priority_low_reg_b[piw_pkg::REG_B_ADC];
   end

   assign global_irq_gate = i_irq_enable_reg_a[piw_pkg::GATE_BIT];
   assign src_gated       = src_raw & src_en & {piw_pkg::NUM_SRC{global_irq_gate}};
   assign arb_bus.req     = src_gated;

   always_comb begin
      for (int i = 0; i < piw_pkg::NUM_SRC; i++) begin
         arb_bus.lvl[i] = {src_hi[i], src_lo[i]};
      end
   end

   piw_arbiter u_arb (
      .bus (arb_bus)
   );

   // Level of the routine in service is the highest active bit
   always_comb begin
      any_active = |active_ff;
      cur_lvl    = '0;
      reti_mask  = '0;
      for (int l = 0; l < piw_pkg::NUM_LVL; l++) begin
         if (active_ff[l]) begin
            cur_lvl = piw_pkg::LVL_W'(l);
         end
      end
      if (any_active) begin
         reti_mask[cur_lvl] = 1'b1;
      end
   end

   assign take = arb_bus.win_valid && (!any_active || arb_bus.win_lvl > cur_lvl);

   // Request to the core, sampled at the start of an instruction
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         irq_req_ff   <= 1'b0;
         irq_id_ff    <= '0;
         irq_level_ff <= '0;
      end else if (i_instr_start) begin
         irq_req_ff   <= take;
         irq_id_ff    <= arb_bus.win_id;
         irq_level_ff <= arb_bus.win_lvl;
      end else if (i_vector_ack) begin
         irq_req_ff   <= 1'b0;
      end
   end

   // In-service levels
   always_comb begin
      nxt_active = active_ff;
      if (i_reti) begin
         nxt_active = nxt_active & ~reti_mask;
      end
      if (i_vector_ack && irq_req_ff) begin
         nxt_active[irq_level_ff] = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         active_ff <= piw_pkg::ACTIVE_RST;
      end else begin
         active_ff <= nxt_active;
      end
   end

   // Timer control low nibble and brownout trip select
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         tctrl_ff <= piw_pkg::TCTRL_RST;
         trip_ff  <= piw_pkg::TRIP_RST;
      end else begin
         tctrl_ff[piw_pkg::TC_FLAG1] <= pin_flag[1];
         tctrl_ff[piw_pkg::TC_TYPE1] <= i_pin1_trigger_type;
         tctrl_ff[piw_pkg::TC_FLAG0] <= pin_flag[0];
         tctrl_ff[piw_pkg::TC_TYPE0] <= i_pin0_trigger_type;
         trip_ff                     <= {i_brownout_irq_trip_hi, i_brownout_irq_trip_lo};
      end
   end

   // Power reduction modes
   assign wake_idle = |src_gated;
   assign wake_pd   = |(src_gated & piw_pkg::PD_WAKE_MASK);

   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         piw_pkg::PWR_RUN: begin
            if (i_pdown_enter) begin
               nxt_mode = piw_pkg::PWR_PDOWN;
            end else if (i_idle_enter) begin
               nxt_mode = piw_pkg::PWR_IDLE;
            end
         end
         piw_pkg::PWR_IDLE: begin
            if (wake_idle) begin
               nxt_mode = piw_pkg::PWR_RUN;
            end
         end
         piw_pkg::PWR_PDOWN: begin
            if (wake_pd) begin
               nxt_mode = piw_pkg::PWR_RUN;
            end
         end
         default: begin
            nxt_mode = piw_pkg::PWR_RUN;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         mode_ff       <= piw_pkg::PWR_RUN;
         core_run_ff   <= 1'b1;
         periph_run_ff <= 1'b1;
         osc_run_ff    <= 1'b1;
         wake_ff       <= 1'b0;
      end else begin
         mode_ff       <= nxt_mode;
         core_run_ff   <= nxt_mode == piw_pkg::PWR_RUN;
         periph_run_ff <= nxt_mode != piw_pkg::PWR_PDOWN;
         osc_run_ff    <= nxt_mode != piw_pkg::PWR_PDOWN;
         wake_ff       <= mode_ff != piw_pkg::PWR_RUN && nxt_mode == piw_pkg::PWR_RUN;
      end
   end

   assign o_irq_req           = irq_req_ff;
   assign o_irq_id            = irq_id_ff;
   assign o_irq_level         = irq_level_ff;
   assign o_active_levels     = active_ff;
   assign o_timer_control_lo  = tctrl_ff;
   assign o_brownout_trip_sel = trip_ff;
   assign o_core_run          = core_run_ff;
   assign o_periph_run        = periph_run_ff;
   assign o_osc_run           = osc_run_ff;
   assign o_wake              = wake_ff;

   // Reference values for the checks below
   always_comb begin
      max_lvl   = '0;
      lower_tie = 1'b0;
      for (int i = 0; i < piw_pkg::NUM_SRC; i++) begin
         if (src_gated[i] && arb_bus.lvl[i] > max_lvl) begin
            max_lvl = arb_bus.lvl[i];
         end
      end
      for (int i = 0; i < piw_pkg::NUM_SRC; i++) begin
         if (src_gated[i] && arb_bus.lvl[i] == max_lvl && piw_pkg::ID_W'(i) < arb_bus.win_id) begin
            lower_tie = 1'b1;
         end
      end
   end

   a_gate_blocks_req : assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_instr_start && !global_irq_gate |=> !o_irq_req)
      else $error("Request raised with global gate cleared");
   a_disabled_no_req : assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_instr_start && (src_raw & src_en) == '0 |=> !o_irq_req)
      else $error("Request raised with no enabled source");
   a_no_equal_preempt : assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_instr_start && any_active && arb_bus.win_lvl <= cur_lvl |=> !o_irq_req)
      else $error("Routine preempted by equal or lower level");
   a_top_level_locked : assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_instr_start && active_ff[piw_pkg::NUM_LVL-1] |=> !o_irq_req)
      else $error("Highest level routine was preempted");
   a_higher_level_wins : assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_instr_start && take |=> o_irq_req && o_irq_level == $past(max_lvl))
      else $error("Selected request is not of the highest pending level");
   a_poll_order_tie : assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_instr_start && take |=> o_irq_id == $past(arb_bus.win_id) && !$past(lower_tie))
      else $error("Polling order not applied among equal levels");
   a_poll_keeps_level : assert property (@(posedge i_clk_sys) disable iff (i_rst)
      arb_bus.win_valid |-> arb_bus.win_lvl == max_lvl && src_gated[arb_bus.win_id])
      else $error("Polling order overrode a level difference");
   a_idle_wakes : assert property (@(posedge i_clk_sys) disable iff (i_rst)
      mode_ff == piw_pkg::PWR_IDLE && wake_idle |=> o_core_run && o_wake ##1 !o_wake)
      else $error("Enabled source did not end idle");
   a_pin_wakes_pdown : assert property (@(posedge i_clk_sys) disable iff (i_rst)
      mode_ff == piw_pkg::PWR_PDOWN && src_gated[piw_pkg::SRC_EXT0] |=> o_core_run && o_osc_run)
      else $error("Pin request did not end power-down");
   a_pdown_osc_off : assert property (@(posedge i_clk_sys) disable iff (i_rst)
      mode_ff == piw_pkg::PWR_RUN && i_pdown_enter |=> !o_osc_run && !o_core_run && !o_periph_run)
      else $error("Oscillator still running in power-down");
endmodule

// file: verification/piw_core_model.sv
// Core side model: instruction boundary and vector acknowledge
`timescale 1ns/100ps
module piw_core_model (
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   input  wire logic i_irq_req,
   input  wire logic i_start,
   input  wire logic i_ack_en,
   output logic      o_instr_start,
   output logic      o_vector_ack
);
   // Boundary pulse one cycle after the bench asks for it
   always_ff @(posedge i_clk_sys) begin
      o_instr_start <= i_start & ~i_rst;
   end
   // Vectors only while a request stands, one pulse per request
   always_ff @(posedge i_clk_sys) begin
      o_vector_ack <= ~i_rst & i_ack_en & i_irq_req & ~o_vector_ack;
   end
endmodule

// file: verification/testbench.sv
// Self-checking bench of the interrupt and wake unit
`timescale 1ns/100ps
module testbench;
   logic        clk = 1'b0, rst = 1'b1, bod = 1'b0, ty0 = 1'b0, ty1 = 1'b0, thi = 1'b0, tlo = 1'b0;
   logic        reti = 1'b0, idle = 1'b0, pdn = 1'b0, start = 1'b0, ack_en = 1'b0, ist, vack;
   logic [1:0]  pin = 2'h3, trip;
   logic [11:0] preq = 12'h000;
   logic [7:0]  ena = 8'h00, enb = 8'h00, pla = 8'h00, pha = 8'h00, plb = 8'h00, phb = 8'h00;
   logic        irq, crun, prun, orun, wake;
   logic [3:0]  id, act, tc;
   logic [1:0]  lvl;
   logic [31:0] seed = 32'h531f;
   int          n_mismatch = 0, samples_checked = 0, cyc = 0;

   piw_top piw_top_i (.i_clk_sys(clk), .i_rst(rst), .i_ext_pin(pin), .i_periph_req(preq),
      .i_brownout_det(bod), .i_irq_enable_reg_a(ena), .i_irq_enable_reg_b(enb),
      .i_priority_low_reg_a(pla), .i_priority_high_reg_a(pha), .i_priority_low_reg_b(plb),
      .i_priority_high_reg_b(phb), .i_pin0_trigger_type(ty0), .i_pin1_trigger_type(ty1),
      .i_pin_flag_clr(2'h0), .i_brownout_irq_trip_hi(thi), .i_brownout_irq_trip_lo(tlo),
      .i_instr_start(ist), .i_vector_ack(vack), .i_reti(reti), .i_idle_enter(idle),
      .i_pdown_enter(pdn), .o_irq_req(irq), .o_irq_id(id), .o_irq_level(lvl),
      .o_active_levels(act), .o_timer_control_lo(tc), .o_brownout_trip_sel(trip),
      .o_core_run(crun), .o_periph_run(prun), .o_osc_run(orun), .o_wake(wake));
   piw_core_model piw_core_model_i (.i_clk_sys(clk), .i_rst(rst), .i_irq_req(irq), .i_start(start),
      .i_ack_en(ack_en), .o_instr_start(ist), .o_vector_ack(vack));

   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         complete_run();
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Bit of a source in the split register layout
   function automatic logic pick(logic [7:0] a, logic [7:0] b, int s);
      return s < 7 ? a[s] : (s < 10 ? b[s-7] : b[s-4]);
   endfunction
   // Highest level wins, lowest source number among equals
   function automatic logic [6:0] exp_win();
      logic [6:0] w;
      logic [1:0] l;
      w = 7'h00;
      for (int s = 0; s < 12; s++) begin
         l = {pick(pha, phb, s), pick(pla, plb, s)};
         if (ena[7] && pick(ena, enb, s) && preq[s] && s != 0 && s != 2 && s != 5)
            if (!w[6] || l > w[1:0]) w = {1'b1, 4'(s), l};
      end
      return w;
   endfunction

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic arb(input logic ack, input logic [6:0] e);
      @(posedge clk) start <= 1'b1;
      @(posedge clk) start <= 1'b0;
      // Acknowledge only the request latched by this boundary
      @(posedge clk) ack_en <= ack;
      #1 chk({irq, id, lvl}, e);
      @(posedge clk) ack_en <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic pulse_reti();
      @(posedge clk) reti <= 1'b1;
      @(posedge clk) reti <= 1'b0;
   endtask
   task automatic wait_run();
      for (int i = 0; i < 8 && crun !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      #1 chk({irq, id, lvl, act, tc, trip, crun, prun, orun, wake}, 24'h00000e);
      for (int k = 0; k < 40; k++) begin
         @(posedge clk) {ena, enb, pla, pha} <= xs() & {k % 5 == 0 ? 8'h7f : 8'hff, 24'hffffff}
            | {k % 7 == 0 ? 8'hff : 8'h00, 24'h000000};
         {plb, phb, preq} <= 28'(xs());
         #1 arb(1'b0, exp_win());
      end
      @(posedge clk) {ena, enb, pla, plb, phb} <= {8'h9a, 8'h00, 8'h10, 16'h0000};
      pha <= 8'h1a;
      preq <= 12'h002;
      arb(1'b1, {1'b1, 4'h1, 2'h2});
      chk(act, 4'h4);
      preq <= 12'h008;
      arb(1'b0, {1'b0, 4'h3, 2'h2});
      preq <= 12'h010;
      arb(1'b1, {1'b1, 4'h4, 2'h3});
      chk(act, 4'hc);
      pla <= 8'h18;
      preq <= 12'h008;
      arb(1'b0, {1'b0, 4'h3, 2'h3});
      pulse_reti();
      #1 chk(act, 4'h4);
      pulse_reti();
      {ena, pha, pla, preq} <= {8'h81, 28'h0000000};
      {ty0, ty1} <= 2'h3;
      @(posedge clk) pin <= 2'h0;
      repeat (5) @(posedge clk);
      #1 chk(tc, 4'hf);
      pin <= 2'h3;
      arb(1'b1, {1'b1, 4'h0, 2'h0});
      @(posedge clk);
      #1 chk(tc, 4'hd);
      pulse_reti();
      {ty0, ty1} <= 2'h0;
      pin[0] <= 1'b0;
      repeat (5) @(posedge clk);
      #1 chk(tc, 4'h2);
      pin[0] <= 1'b1;
      repeat (5) @(posedge clk);
      #1 chk(tc, 4'h0);
      ena <= 8'h83;
      @(posedge clk) idle <= 1'b1;
      @(posedge clk) idle <= 1'b0;
      @(posedge clk);
      #1 chk({crun, prun, orun}, 3'h3);
      preq <= 12'h002;
      wait_run();
      chk({crun, wake}, 2'h3);
      @(posedge clk) preq <= 12'h000;
      pdn <= 1'b1;
      @(posedge clk) pdn <= 1'b0;
      @(posedge clk) preq <= 12'h002;
      repeat (4) @(posedge clk);
      #1 chk({crun, prun, orun}, 3'h0);
      pin[0] <= 1'b0;
      wait_run();
      chk({crun, wake}, 2'h3);
      {pin, preq, ena} <= {2'h3, 12'h000, 8'h80};
      {thi, tlo, bod} <= 3'h5;
      repeat (4) @(posedge clk);
      #1 chk(trip, 2'h2);
      arb(1'b0, 7'h00);
      ena <= 8'ha0;
      arb(1'b0, {1'b1, 4'h5, 2'h0});
      complete_run();
   end
endmodule
